// *** common/mpc_pkg.sv ***
/*
 * Constants, field layout and carrier types for the multipurpose pin
 * and converter power control block.
 * Assumes a single 100 MHz core clock and a 16-bit control-port address.
 */
package mpc_pkg;

    localparam int          NUM_PINS       = 12;
    localparam int          FIELD_W        = 4;
    localparam int          CFG_W          = 24;
    localparam int          REG16_W        = 16;
    localparam int          ADDR_W         = 16;
    localparam int          NUM_AUX_CHAN   = 4;

    // control-port register addresses
    localparam logic [15:0] ADDR_PIN_FUNC_LOW  = 16'h0820;
    localparam logic [15:0] ADDR_PIN_FUNC_HIGH = 16'h0821;
    localparam logic [15:0] ADDR_CONV_POWER    = 16'h0822;
    localparam logic [15:0] ADDR_AUX_ENABLE    = 16'h0824;
    localparam logic [15:0] ADDR_OSC_SHUTDOWN  = 16'h0826;
    localparam logic [15:0] ADDR_DAC_INIT      = 16'h0827;

    // reset values
    localparam logic [23:0] RST_PIN_FUNC   = 24'h000000;
    localparam logic [15:0] RST_REG16      = 16'h0000;

    // writable bits; all others are reserved and read as zero
    localparam logic [15:0] MASK_CONV_POWER = 16'h03EF;
    localparam logic [15:0] MASK_AUX_ENABLE = 16'h8000;
    localparam logic [15:0] MASK_OSC        = 16'h0004;
    localparam logic [15:0] MASK_DAC_INIT   = 16'h0003;

    // field positions
    localparam int          INVERT_BIT       = 3;
    localparam int          SMOOTH_LSB       = 8;
    localparam int          MAIN_ADC_PD_BIT  = 7;
    localparam int          REF_BUF_PD_BIT   = 6;
    localparam int          REF_PD_BIT       = 5;
    localparam int          DAC_PD_LSB       = 0;
    localparam int          AUX_ON_BIT       = 15;
    localparam int          OSC_SHUT_BIT     = 2;
    localparam int          DAC_INIT_LSB     = 0;

    localparam logic [3:0]  AUX_CODE         = 4'hF;
    localparam int          SERIAL_OUT_FIRST = 6;

    // pin carrying each auxiliary converter channel, channel 0 first
    localparam int          AUX_PIN [NUM_AUX_CHAN] = '{9, 2, 3, 8};

    // debounce settling time
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          DEBOUNCE_TIME_NS = 10000;
    localparam int          DEBOUNCE_CYCLES  =
        (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DEB_CNT_W        = 10;

    typedef enum logic [2:0] {
        FN_GPIO_IN_DEB = 3'b000,
        FN_GPIO_IN_RAW = 3'b001,
        FN_GPIO_OUT    = 3'b010,
        FN_OPEN_COLL   = 3'b011,
        FN_SERIAL      = 3'b100,
        FN_RSVD5       = 3'b101,
        FN_RSVD6       = 3'b110,
        FN_AUX_OR_NA   = 3'b111
    } mpc_func_t;

    typedef struct packed {
        logic       mainAdcPowerdown;
        logic       refBufferPowerdown;
        logic       referencePowerdown;
        logic [3:0] dacPowerdown;
    } mpc_power_t;

    typedef struct packed {
        logic       auxConverterOn;
        logic [1:0] auxSmoothingSelect;
        logic [3:0] chanActive;
    } mpc_aux_t;

endpackage

// *** rtl/mpc_debounce.sv ***
/*
 * Single-input debouncer: the output follows the input only after the
 * input has held a new level for the full settling time.
 * Assumes the input is already synchronous to core_clk.
 */
module mpc_debounce
    import mpc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic rawIn,
    output logic      stableOut
);

    logic [DEB_CNT_W-1:0] settleCnt;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settleCnt <= '0;
            stableOut <= 1'b0;
        end
        else if (rawIn == stableOut)
        begin
            settleCnt <= '0;
        end
        else if (settleCnt == DEB_CNT_W'(DEBOUNCE_CYCLES - 1))
        begin
            settleCnt <= '0;
            stableOut <= rawIn;
        end
        else
        begin
            settleCnt <= settleCnt + 1'b1;
        end
    end

    // a change of output needs the new level on the input just before
    settle_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(stableOut) |-> $past(rawIn) == stableOut)
        else $error("debounced output changed against its input");

endmodule

// *** rtl/mpc_pin_ctrl.sv ***
/*
 * Multipurpose pin function select and converter power control registers.
 * Assumes the control port presents one access per cycle, synchronous to
 * core_clk, and that pin inputs are already synchronous to core_clk.
 */
// Summary of operation
// - two 24-bit registers, twelve 4-bit pin fields
// - field top bit inverts the pin signal
// - pull-up on for any digital input pin
// - pins 0-5 in low register nibbles
// - pins 6-11 in high register nibbles
// - codes 0-4 select input, output, serial functions
// - codes 8-C are inverted versions of 0-4
// - code 1111 routes pins 2,3,8,9 to auxiliary converter
// - bits 9:8 select auxiliary converter smoothing
// - power register holds converter and reference power-downs
// - bit 15 turns auxiliary converter on
// - bit 2 shuts the crystal oscillator down
// - every pin individually selects its function
// - aux channels 1,2,3,0 on pins 2,3,8,9
module mpc_pin_ctrl
    import mpc_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [CFG_W-1:0]    regWrData,
    input  wire logic                regWrEn,
    input  wire logic                regRdEn,
    output logic      [CFG_W-1:0]    regRdData,
    input  wire logic [NUM_PINS-1:0] pinIn,
    output logic      [NUM_PINS-1:0] pinOut,
    output logic      [NUM_PINS-1:0] pinOe,
    output logic      [NUM_PINS-1:0] pullUpEn,
    input  wire logic [NUM_PINS-1:0] coreGpioOut,
    output logic      [NUM_PINS-1:0] coreGpioIn,
    input  wire logic [NUM_PINS-1:0] serialOutData,
    output logic      [NUM_PINS-1:0] serialInData,
    output logic      [NUM_PINS-1:0] auxRouteEn,
    output mpc_aux_t                 auxCtrl,
    output mpc_power_t               powerCtrl,
    output logic                     oscillatorShutdown,
    output logic      [1:0]          dacInitCode
);

    logic [CFG_W-1:0]          pinFuncLow;
    logic [CFG_W-1:0]          pinFuncHigh;
    logic [REG16_W-1:0]        convPower;
    logic [REG16_W-1:0]        auxEnable;
    logic [REG16_W-1:0]        oscCtrl;
    logic [REG16_W-1:0]        dacInit;
    logic [2*CFG_W-1:0]        allCfg;
    logic [NUM_PINS-1:0]       debounced;
    logic [NUM_PINS-1:0]       next_pinOut;
    logic [NUM_PINS-1:0]       next_pinOe;
    logic [NUM_PINS-1:0]       next_pullUpEn;
    logic [NUM_PINS-1:0]       next_coreGpioIn;
    logic [NUM_PINS-1:0]       next_serialInData;
    logic [NUM_PINS-1:0]       next_auxRouteEn;
    logic [NUM_AUX_CHAN-1:0]   next_chanActive;

    // pin p sits at bits 4p+3:4p of the joined pair
    assign allCfg = {pinFuncHigh, pinFuncLow};

    function automatic logic [3:0] fieldOf(input logic [2*CFG_W-1:0] cfg, input int p);
        return cfg[p*FIELD_W +: FIELD_W];
    endfunction

    function automatic logic hasAux(input int p);
        logic found;
        found = 1'b0;
        for (int c = 0; c < NUM_AUX_CHAN; c++)
        begin
            if (AUX_PIN[c] == p)
            begin
                found = 1'b1;
            end
        end
        return found;
    endfunction

    function automatic logic isDigitalIn(input logic [3:0] code, input int p);
        return (code[2:0] == FN_GPIO_IN_DEB) || (code[2:0] == FN_GPIO_IN_RAW)
            || ((code[2:0] == FN_SERIAL) && (p < SERIAL_OUT_FIRST));
    endfunction

    // control-port writes; reserved bits are never stored
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinFuncLow  <= RST_PIN_FUNC;
            pinFuncHigh <= RST_PIN_FUNC;
            convPower   <= RST_REG16;
            auxEnable   <= RST_REG16;
            oscCtrl     <= RST_REG16;
            dacInit     <= RST_REG16;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                ADDR_PIN_FUNC_LOW:  pinFuncLow  <= regWrData;
                ADDR_PIN_FUNC_HIGH: pinFuncHigh <= regWrData;
                ADDR_CONV_POWER:    convPower   <= regWrData[15:0] & MASK_CONV_POWER;
                ADDR_AUX_ENABLE:    auxEnable   <= regWrData[15:0] & MASK_AUX_ENABLE;
                ADDR_OSC_SHUTDOWN:  oscCtrl     <= regWrData[15:0] & MASK_OSC;
                ADDR_DAC_INIT:      dacInit     <= regWrData[15:0] & MASK_DAC_INIT;
                default:            ;
            endcase
        end
    end

    // control-port reads; unmapped addresses answer zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdData <= '0;
        end
        else if (regRdEn)
        begin
            case (regAddr)
                ADDR_PIN_FUNC_LOW:  regRdData <= pinFuncLow;
                ADDR_PIN_FUNC_HIGH: regRdData <= pinFuncHigh;
                ADDR_CONV_POWER:    regRdData <= {8'h00, convPower};
                ADDR_AUX_ENABLE:    regRdData <= {8'h00, auxEnable};
                ADDR_OSC_SHUTDOWN:  regRdData <= {8'h00, oscCtrl};
                ADDR_DAC_INIT:      regRdData <= {8'h00, dacInit};
                default:            regRdData <= '0;
            endcase
        end
    end

    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_deb
        mpc_debounce u_deb
        (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .rawIn     (pinIn[g]),
            .stableOut (debounced[g])
        );
    end

    // per-pin function decode
    always_comb
    begin
        logic [3:0] code;
        logic       inv;
        code              = '0;
        inv               = 1'b0;
        next_pinOut       = '0;
        next_pinOe        = '0;
        next_pullUpEn     = '0;
        next_coreGpioIn   = '0;
        next_serialInData = '0;
        next_auxRouteEn   = '0;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            code = fieldOf(allCfg, p);
            inv  = code[INVERT_BIT];
            next_pullUpEn[p] = isDigitalIn(code, p);
            unique case (mpc_func_t'(code[2:0]))
                FN_GPIO_IN_DEB: next_coreGpioIn[p] = debounced[p] ^ inv;
                FN_GPIO_IN_RAW: next_coreGpioIn[p] = pinIn[p] ^ inv;
                FN_GPIO_OUT:
                begin
                    next_pinOe[p]  = 1'b1;
                    next_pinOut[p] = coreGpioOut[p] ^ inv;
                end
                FN_OPEN_COLL:
                begin
                    next_pinOut[p] = 1'b0;
                    next_pinOe[p]  = ~(coreGpioOut[p] ^ inv);
                end
                FN_SERIAL:
                begin
                    if (p < SERIAL_OUT_FIRST)
                    begin
                        next_serialInData[p] = pinIn[p] ^ inv;
                    end
                    else
                    begin
                        next_pinOe[p]  = 1'b1;
                        next_pinOut[p] = serialOutData[p] ^ inv;
                    end
                end
                FN_RSVD5:       ;
                FN_RSVD6:       ;
                FN_AUX_OR_NA:   next_auxRouteEn[p] = (code == AUX_CODE) && hasAux(p);
            endcase
        end
    end

    always_comb
    begin
        for (int c = 0; c < NUM_AUX_CHAN; c++)
        begin
            next_chanActive[c] = auxEnable[AUX_ON_BIT]
                && (fieldOf(allCfg, AUX_PIN[c]) == AUX_CODE);
        end
    end

    // pin-side outputs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOut       <= '0;
            pinOe        <= '0;
            pullUpEn     <= '0;
            coreGpioIn   <= '0;
            serialInData <= '0;
            auxRouteEn   <= '0;
        end
        else
        begin
            pinOut       <= next_pinOut;
            pinOe        <= next_pinOe;
            pullUpEn     <= next_pullUpEn;
            coreGpioIn   <= next_coreGpioIn;
            serialInData <= next_serialInData;
            auxRouteEn   <= next_auxRouteEn;
        end
    end

    // converter, reference and oscillator controls
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auxCtrl            <= '0;
            powerCtrl          <= '0;
            oscillatorShutdown <= 1'b0;
            dacInitCode        <= 2'h0;
        end
        else
        begin
            auxCtrl.auxConverterOn     <= auxEnable[AUX_ON_BIT];
            auxCtrl.auxSmoothingSelect <= convPower[SMOOTH_LSB +: 2];
            auxCtrl.chanActive         <= next_chanActive;
            powerCtrl.mainAdcPowerdown   <= convPower[MAIN_ADC_PD_BIT];
            powerCtrl.refBufferPowerdown <= convPower[REF_BUF_PD_BIT];
            powerCtrl.referencePowerdown <= convPower[REF_PD_BIT];
            powerCtrl.dacPowerdown       <= convPower[DAC_PD_LSB +: 4];
            oscillatorShutdown <= oscCtrl[OSC_SHUT_BIT];
            dacInitCode        <= dacInit[DAC_INIT_LSB +: 2];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cfg_write_a: assert property (
        regWrEn && regAddr == ADDR_PIN_FUNC_HIGH
        |=> ##1 (fieldOf(allCfg, 11) == $past(regWrData[23:20], 2)))
        else $error("pin 11 field not taken from high register bits 23:20");

    invert_out_a: assert property (
        fieldOf(allCfg, 0) == 4'hA
        |=> pinOe[0] && (pinOut[0] == ~$past(coreGpioOut[0])))
        else $error("inverted gpio output wrong");

    pullup_input_a: assert property (
        ((fieldOf(allCfg, 1) == 4'h1) |=> pullUpEn[1])
        and ((fieldOf(allCfg, 4) == 4'hC) |=> pullUpEn[4]))
        else $error("pull-up missing on digital input");

    open_coll_a: assert property (
        fieldOf(allCfg, 5) == 4'h3 |=> !pinOut[5] && (pinOe[5] == !$past(coreGpioOut[5])))
        else $error("open-collector pin drove high or wrong enable");

    aux_route_a: assert property (
        ((fieldOf(allCfg, 0) == AUX_CODE) |=> !auxRouteEn[0] && !pinOe[0])
        and ((fieldOf(allCfg, 9) == AUX_CODE) |=> auxRouteEn[9] && !pinOe[9]))
        else $error("aux code routed a pin without a channel or drove it");

    serial_out_a: assert property (
        fieldOf(allCfg, 7) == 4'h4 |=> pinOe[7] && pinOut[7] == $past(serialOutData[7]))
        else $error("serial output pin not driven from serial data");

    smoothing_a: assert property (
        regWrEn && regAddr == ADDR_CONV_POWER
        |=> ##1 auxCtrl.auxSmoothingSelect == $past(regWrData[9:8], 2))
        else $error("smoothing select not updated two cycles after write");

    osc_shut_a: assert property (
        regWrEn && regAddr == ADDR_OSC_SHUTDOWN
        |=> ##1 oscillatorShutdown == $past(regWrData[2], 2))
        else $error("oscillator shutdown not following bit 2");

    chan_needs_on_a: assert property (
        auxCtrl.chanActive != '0 |-> auxCtrl.auxConverterOn)
        else $error("aux channel active with converter off");

    reserved_zero_a: assert property (
        regRdEn && regAddr == ADDR_CONV_POWER |=> (regRdData & ~24'(MASK_CONV_POWER)) == '0)
        else $error("reserved bits read non-zero");

    cover_aux_cov:   cover property (auxCtrl.chanActive[0]);
    cover_gpio_cov:  cover property (pinOe[2] && pinOut[2]);
    cover_debin_cov: cover property ($rose(coreGpioIn[0]));
    cover_ser_cov:   cover property (serialInData[3]);

endmodule

// *** tb/mpc_host_model.sv ***
/*
 * Host controller model that reaches the control registers through the register port.
 * Assumes the bench calls one task at a time, after reset has been released.
 */
module mpc_host_model
    import mpc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    output logic     [ADDR_W-1:0] regAddr,
    output logic     [CFG_W-1:0]  regWrData,
    output logic                  regWrEn,
    output logic                  regRdEn,
    input  wire logic [CFG_W-1:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        regAddr   = '0;
        regWrData = '0;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end

    // idle lines carry the inverse of the last value so stale data is never trusted
    task automatic writeReg(input logic [ADDR_W-1:0] addr, input logic [CFG_W-1:0] data);
        @(posedge core_clk);
        regAddr   <= addr;
        regWrData <= data;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn   <= 1'b0;
        regAddr   <= ~addr;
        regWrData <= ~data;
    endtask

    task automatic readReg(input logic [ADDR_W-1:0] addr, output logic [CFG_W-1:0] data);
        @(posedge core_clk);
        regAddr <= addr;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        regAddr <= ~addr;
        #1;
        data = regRdData;
    endtask

    task automatic initDacs;
        writeReg(ADDR_DAC_INIT, 24'h000001);
    endtask

    // pin fields must also hold code 1111 for a channel to come alive
    task automatic auxOn(input logic on);
        writeReg(ADDR_AUX_ENABLE, {8'h00, on, 15'h0000});
    endtask
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench for the pin function and converter control registers.
 * Assumes the host model owns the register port and the bench owns the pin side.
 */
module tb
    import mpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int                  LIMIT = 20000;
    localparam logic [NUM_PINS-1:0] PIN_A = 12'h5A3;
    localparam logic [NUM_PINS-1:0] PIN_B = 12'h0F0;
    localparam logic [15:0] ADDRS [8] = '{16'h0820, 16'h0821, 16'h0822, 16'h0824,
                                          16'h0826, 16'h0827, 16'h0823, 16'h0825};
    localparam logic [23:0] MASKS [8] = '{24'hFFFFFF, 24'hFFFFFF, 24'h0003EF, 24'h008000,
                                          24'h000004, 24'h000003, 24'h000000, 24'h000000};

    logic                core_clk;
    logic                rst_n;
    logic [ADDR_W-1:0]   regAddr;
    logic [CFG_W-1:0]    regWrData;
    logic                regWrEn;
    logic                regRdEn;
    logic [CFG_W-1:0]    regRdData;
    logic [NUM_PINS-1:0] pinIn;
    logic [NUM_PINS-1:0] pinOut;
    logic [NUM_PINS-1:0] pinOe;
    logic [NUM_PINS-1:0] pullUpEn;
    logic [NUM_PINS-1:0] coreGpioOut;
    logic [NUM_PINS-1:0] coreGpioIn;
    logic [NUM_PINS-1:0] serialOutData;
    logic [NUM_PINS-1:0] serialInData;
    logic [NUM_PINS-1:0] auxRouteEn;
    mpc_aux_t            auxCtrl;
    mpc_power_t          powerCtrl;
    logic                oscillatorShutdown;
    logic [1:0]          dacInitCode;
    int                  nMismatch = 0;
    int                  checkCount = 0;
    int                  cycles = 0;

    mpc_pin_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
        .coreGpioOut(coreGpioOut), .coreGpioIn(coreGpioIn), .serialOutData(serialOutData),
        .serialInData(serialInData), .auxRouteEn(auxRouteEn), .auxCtrl(auxCtrl),
        .powerCtrl(powerCtrl), .oscillatorShutdown(oscillatorShutdown),
        .dacInitCode(dacInitCode));

    mpc_host_model host (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic completeRun;
        if (nMismatch == 0 && checkCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= LIMIT)
        begin
            nMismatch++;
            completeRun();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // register outputs trail the stored value by one edge
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic testResetValues;
        logic [23:0] d;
        settle();
        check(24'(pullUpEn), 24'h000FFF);
        check(24'(pinOe), 24'h000000);
        for (int i = 0; i < 8; i++)
        begin
            host.readReg(ADDRS[i], d);
            check(d, 24'h000000);
        end
    endtask

    task automatic testReserved;
        logic [23:0] d;
        for (int i = 0; i < 8; i++)
            host.writeReg(ADDRS[i], 24'hFFFFFF);
        for (int i = 0; i < 8; i++)
        begin
            host.readReg(ADDRS[i], d);
            check(d, MASKS[i]);
        end
        settle();
        check(24'(powerCtrl), 24'h00007F);
        check(24'(auxCtrl), 24'h00007F);
        check(24'(oscillatorShutdown), 24'h000001);
        check(24'(dacInitCode), 24'h000003);
        check(24'(auxRouteEn), 24'h00030C);
        check(24'(pinOe | pullUpEn), 24'h000000);
        for (int i = 0; i < 6; i++)
            host.writeReg(ADDRS[i], 24'h000000);
    endtask

    task automatic testLayout;
        logic [23:0] lo;
        logic [23:0] hi;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            lo = (p < 6) ? (24'h000002 << (4 * p)) : 24'h000000;
            hi = (p < 6) ? 24'h000000 : (24'h000002 << (4 * (p - 6)));
            host.writeReg(ADDR_PIN_FUNC_LOW, lo);
            host.writeReg(ADDR_PIN_FUNC_HIGH, hi);
            settle();
            check(24'(pinOe), 24'(12'h001 << p));
            check(24'(pullUpEn), {12'h000, ~(12'h001 << p)});
        end
    endtask

    task automatic testCodes;
        logic [3:0]          c;
        logic                inv;
        logic [NUM_PINS-1:0] eOe, ePull, eOut, eAux, mIn, mSer, flip;
        for (int k = 0; k < 16; k++)
        begin
            c = 4'(k);
            inv = c[INVERT_BIT];
            flip = {NUM_PINS{inv}};
            host.writeReg(ADDR_PIN_FUNC_LOW, {6{c}});
            host.writeReg(ADDR_PIN_FUNC_HIGH, {6{c}});
            settle();
            {eOe, ePull, eOut, eAux, mIn, mSer} = '0;
            for (int p = 0; p < NUM_PINS; p++)
            begin
                case (c[2:0])
                    3'b000: ePull[p] = 1'b1;
                    3'b001:
                    begin
                        ePull[p] = 1'b1;
                        mIn[p]   = 1'b1;
                    end
                    3'b010:
                    begin
                        eOe[p]  = 1'b1;
                        eOut[p] = coreGpioOut[p] ^ inv;
                    end
                    3'b011: eOe[p] = ~(coreGpioOut[p] ^ inv);
                    3'b100:
                    begin
                        eOe[p]   = (p >= SERIAL_OUT_FIRST);
                        ePull[p] = (p < SERIAL_OUT_FIRST);
                        mSer[p]  = (p < SERIAL_OUT_FIRST);
                        eOut[p]  = eOe[p] & (serialOutData[p] ^ inv);
                    end
                    default: ;
                endcase
            end
            for (int ch = 0; ch < NUM_AUX_CHAN; ch++)
                eAux[AUX_PIN[ch]] = (c == AUX_CODE);
            check(24'(pinOe), 24'(eOe));
            check(24'(pullUpEn), 24'(ePull));
            check(24'(pinOut & pinOe), 24'(eOut));
            check(24'(coreGpioIn & mIn), 24'((pinIn ^ flip) & mIn));
            check(24'(serialInData & mSer), 24'((pinIn ^ flip) & mSer));
            check(24'(auxRouteEn), 24'(eAux));
        end
    endtask

    task automatic testAux;
        host.writeReg(ADDR_PIN_FUNC_LOW, 24'h000F00);
        host.writeReg(ADDR_PIN_FUNC_HIGH, 24'h00F000);
        host.auxOn(1'b1);
        settle();
        check(24'(auxCtrl.chanActive), 24'h000003);
        check(24'(auxCtrl.auxConverterOn), 24'h000001);
        check(24'(auxRouteEn), 24'h000204);
        host.auxOn(1'b0);
        settle();
        check(24'(auxCtrl.chanActive), 24'h000000);
    endtask

    task automatic testPower;
        logic [15:0] w;
        logic [15:0] e;
        logic [23:0] d;
        for (int s = 0; s < 4; s++)
        begin
            w = (16'(s) << SMOOTH_LSB) | (16'h0080 >> s) | (16'h0001 << s);
            e = w & 16'h03EF;
            host.writeReg(ADDR_CONV_POWER, {8'h00, w});
            host.readReg(ADDR_CONV_POWER, d);
            check(d, {8'h00, e});
            settle();
            check(24'(auxCtrl.auxSmoothingSelect), 24'(s));
            check(24'(powerCtrl), 24'({e[7:5], e[3:0]}));
        end
    endtask

    task automatic testDacOsc;
        logic [23:0] d;
        host.initDacs();
        host.writeReg(ADDR_OSC_SHUTDOWN, 24'h000004);
        host.readReg(ADDR_DAC_INIT, d);
        check(d, 24'h000001);
        settle();
        check(24'(dacInitCode), 24'h000001);
        check(24'(oscillatorShutdown), 24'h000001);
        host.writeReg(ADDR_OSC_SHUTDOWN, 24'h000000);
        settle();
        check(24'(oscillatorShutdown), 24'h000000);
    endtask

    task automatic testDebounce;
        host.writeReg(ADDR_PIN_FUNC_LOW, 24'h888888);
        host.writeReg(ADDR_PIN_FUNC_HIGH, 24'h888888);
        repeat (DEBOUNCE_CYCLES + 10) @(posedge core_clk);
        #1;
        check(24'(coreGpioIn), {12'h000, ~PIN_A});
        @(posedge core_clk);
        pinIn <= PIN_B;
        repeat (DEBOUNCE_CYCLES - 10) @(posedge core_clk);
        #1;
        check(24'(coreGpioIn), {12'h000, ~PIN_A});
        repeat (20) @(posedge core_clk);
        #1;
        check(24'(coreGpioIn), {12'h000, ~PIN_B});
    endtask

    initial
    begin
        rst_n = 1'b0;
        pinIn = PIN_A;
        coreGpioOut = 12'hA5C;
        serialOutData = 12'h3C6;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        testResetValues();
        testReserved();
        testLayout();
        testCodes();
        testAux();
        testPower();
        testDacOsc();
        testDebounce();
        completeRun();
    end
endmodule
